// ==== core/dpd_consts.vh ====
`ifndef DPD_CONSTS_VH
`define DPD_CONSTS_VH
// Register addresses as {CS0 asserted, CS1 asserted, DA2, DA1, DA0}.
`define DPD_A_DATA 5'h10
`define DPD_A_FEAT 5'h11
`define DPD_A_SCNT 5'h12
`define DPD_A_LLOW 5'h13
`define DPD_A_LMID 5'h14
`define DPD_A_LHIGH 5'h15
`define DPD_A_DEV 5'h16
`define DPD_A_CMD 5'h17
`define DPD_A_DCTL 5'h0E
// Field positions.
`define DPD_DEV_BIT 4
`define DPD_HOB_BIT 7
`define DPD_SRST_BIT 2
`define DPD_NIEN_BIT 1
// Reset values.
`define DPD_RST_BYTE 8'h00
`define DPD_RST_WORD 16'h0000
// Command code that is acted on while answering for the absent unit.
`define DPD_CMD_DIAG 8'h90
// Number of entries in the DMA write word buffer.
`define DPD_BUF_DEPTH 2
`endif

// ==== core/dpd_port_decode.v ====
`timescale 1ns/100ps
`include "dpd_consts.vh"
module dpd_port_decode (
    input wire core_clk,
    input wire rst_n,
    input wire cs0N,
    input wire cs1N,
    input wire [2:0] devAddr,
    input wire diorN,
    input wire diowN,
    input wire dmackN,
    input wire [15:0] ddIn,
    output reg [15:0] ddOut,
    output reg ddOeN,
    input wire devNumber,
    input wire dev1Absent,
    input wire hasLba48,
    input wire hasPacket,
    input wire busy,
    input wire drqIn,
    input wire dmaReq,
    input wire [7:0] errorIn,
    input wire [15:0] dmaRdData,
    input wire dmaRdValid,
    output reg dmaRdTake,
    output reg [15:0] dmaWrData,
    output reg dmaWrValid,
    input wire dmaWrReady,
    output reg selected,
    output reg nIenOut,
    output reg srstOut,
    output reg [7:0] featOut,
    output reg [7:0] cmdOut,
    output reg cmdStrobe,
    output reg diagStrobe,
    output reg burstEnd,
    output reg hostError
);
    localparam ST_IDLE = 3'b001;
    localparam ST_READ = 3'b010;
    localparam ST_HOLD = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] devCtl_reg;
    reg [7:0] dev_reg;
    reg [7:0] feat_reg;
    reg [7:0] featPrev_reg;
    reg [7:0] cnt_reg;
    reg [7:0] cntPrev_reg;
    reg [7:0] lLow_reg;
    reg [7:0] lLowPrev_reg;
    reg [7:0] lMid_reg;
    reg [7:0] lMidPrev_reg;
    reg [7:0] lHigh_reg;
    reg [7:0] lHighPrev_reg;
    reg [7:0] cmd_reg;
    reg [7:0] rdByte;
    wire rdFire;
    wire wrFire;
    wire [4:0] target;
    wire inDma;
    wire dmaMove;
    wire proxy;
    wire hob;
    wire wrBufReady;
    wire [15:0] wrBufData;
    wire wrBufValid;
    wire wrLoad;

    // One pulse at the start of each strobe; a long strobe acts only once.
    dpd_strobe_edge uRdEdge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .strobeN(diorN),
        .fire(rdFire)
    );
    dpd_strobe_edge uWrEdge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .strobeN(diowN),
        .fire(wrFire)
    );

    // DMA words from the host pass through a buffer; a stalled core keeps three words and a fourth push is dropped.
    dpd_word_buf #(.WIDTH(16)) uWrBuf (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .inData(ddIn),
        .inValid(wrFire & dmaMove),
        .inReady(wrBufReady),
        .outData(wrBufData),
        .outValid(wrBufValid),
        .outReady(wrLoad)
    );

    // Target code from the chip selects and address, taken at the strobe.
    assign target = {~cs0N, ~cs1N, devAddr};
    assign inDma = ~dmackN;
    assign dmaMove = inDma & cs0N & cs1N & dmaReq & (busy | drqIn);
    // Proxy answers only while the absent unit is addressed and idle.
    assign proxy = dev_reg[`DPD_DEV_BIT] & ~devNumber & dev1Absent & ~busy & ~drqIn;
    assign hob = hasLba48 & devCtl_reg[`DPD_HOB_BIT];
    // The output stage takes a new word only when it is empty or its word is being taken.
    assign wrLoad = ~dmaWrValid | dmaWrReady;

    // Read data selection for proxy answers; unlisted targets drive nothing.
    always @* begin
        rdByte = `DPD_RST_BYTE;
        case (target)
            `DPD_A_DCTL: rdByte = `DPD_RST_BYTE;
            `DPD_A_CMD: rdByte = `DPD_RST_BYTE;
            `DPD_A_FEAT: rdByte = errorIn;
            `DPD_A_SCNT: rdByte = hasPacket ? `DPD_RST_BYTE : (hob ? cntPrev_reg : cnt_reg);
            `DPD_A_LLOW: rdByte = hasPacket ? `DPD_RST_BYTE : (hob ? lLowPrev_reg : lLow_reg);
            `DPD_A_LMID: rdByte = hasPacket ? `DPD_RST_BYTE : (hob ? lMidPrev_reg : lMid_reg);
            `DPD_A_LHIGH: rdByte = hasPacket ? `DPD_RST_BYTE : (hob ? lHighPrev_reg : lHigh_reg);
            `DPD_A_DEV: rdByte = hasPacket ? `DPD_RST_BYTE : (dev_reg | 8'h10);
            default: rdByte = `DPD_RST_BYTE;
        endcase
    end

    // Read drive sequencing: drive for the strobe, release when it ends.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (rdFire) begin
                    state_next = ST_READ;
                end
            end
            ST_READ: state_next = ST_HOLD;
            ST_HOLD: begin
                if (diorN) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Register writes, pulses and the data bus driver.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            devCtl_reg <= `DPD_RST_BYTE;
            dev_reg <= `DPD_RST_BYTE;
            feat_reg <= `DPD_RST_BYTE;
            featPrev_reg <= `DPD_RST_BYTE;
            cnt_reg <= `DPD_RST_BYTE;
            cntPrev_reg <= `DPD_RST_BYTE;
            lLow_reg <= `DPD_RST_BYTE;
            lLowPrev_reg <= `DPD_RST_BYTE;
            lMid_reg <= `DPD_RST_BYTE;
            lMidPrev_reg <= `DPD_RST_BYTE;
            lHigh_reg <= `DPD_RST_BYTE;
            lHighPrev_reg <= `DPD_RST_BYTE;
            cmd_reg <= `DPD_RST_BYTE;
            ddOut <= `DPD_RST_WORD;
            ddOeN <= 1'b1;
            dmaRdTake <= 1'b0;
            dmaWrData <= `DPD_RST_WORD;
            dmaWrValid <= 1'b0;
            selected <= 1'b0;
            nIenOut <= 1'b0;
            srstOut <= 1'b0;
            featOut <= `DPD_RST_BYTE;
            cmdOut <= `DPD_RST_BYTE;
            cmdStrobe <= 1'b0;
            diagStrobe <= 1'b0;
            burstEnd <= 1'b0;
            hostError <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmdStrobe <= 1'b0;
            diagStrobe <= 1'b0;
            burstEnd <= 1'b0;
            hostError <= 1'b0;
            dmaRdTake <= 1'b0;
            // Reloading only when empty or after a hand-over keeps a stalled word from being overwritten.
            if (wrLoad) begin
                dmaWrData <= wrBufData;
                dmaWrValid <= wrBufValid;
            end
            selected <= (dev_reg[`DPD_DEV_BIT] == devNumber);
            nIenOut <= devCtl_reg[`DPD_NIEN_BIT];
            srstOut <= devCtl_reg[`DPD_SRST_BIT];
            featOut <= feat_reg;
            cmdOut <= cmd_reg;
            // The bus is released once the strobe ends, but never in the first drive cycle.
            if (diorN && state_reg != ST_READ) begin
                ddOeN <= 1'b1;
            end
            if (inDma && (rdFire || wrFire)) begin
                if (!cs0N || !cs1N) begin
                    hostError <= 1'b1;
                end else if (!dmaReq) begin
                    burstEnd <= 1'b1;
                end else if (dmaMove && rdFire) begin
                    ddOut <= dmaRdValid ? dmaRdData : `DPD_RST_WORD;
                    ddOeN <= 1'b0;
                    dmaRdTake <= dmaRdValid;
                end else if (!dmaMove) begin
                    hostError <= 1'b1;
                end
            end else if (!inDma && proxy && rdFire) begin
                case (target)
                    `DPD_A_DCTL, `DPD_A_CMD, `DPD_A_FEAT, `DPD_A_SCNT, `DPD_A_LLOW,
                    `DPD_A_LMID, `DPD_A_LHIGH, `DPD_A_DEV: begin
                        ddOut <= {8'h00, rdByte};
                        ddOeN <= 1'b0;
                    end
                    default: ddOeN <= 1'b1;
                endcase
            end else if (!inDma && proxy && wrFire) begin
                case (target)
                    `DPD_A_DCTL: devCtl_reg <= ddIn[7:0];
                    `DPD_A_FEAT: begin
                        featPrev_reg <= feat_reg;
                        feat_reg <= ddIn[7:0];
                    end
                    `DPD_A_SCNT: begin
                        cntPrev_reg <= cnt_reg;
                        cnt_reg <= ddIn[7:0];
                    end
                    `DPD_A_LLOW: begin
                        lLowPrev_reg <= lLow_reg;
                        lLow_reg <= ddIn[7:0];
                    end
                    `DPD_A_LMID: begin
                        lMidPrev_reg <= lMid_reg;
                        lMid_reg <= ddIn[7:0];
                    end
                    `DPD_A_LHIGH: begin
                        lHighPrev_reg <= lHigh_reg;
                        lHigh_reg <= ddIn[7:0];
                    end
                    `DPD_A_DEV: dev_reg <= ddIn[7:0];
                    `DPD_A_CMD: begin
                        cmd_reg <= ddIn[7:0];
                        diagStrobe <= (ddIn[7:0] == `DPD_CMD_DIAG);
                    end
                    default: cmd_reg <= cmd_reg;
                endcase
            end else if (!inDma && !proxy && wrFire && target == `DPD_A_DEV) begin
                // The own unit still tracks selection writes so it can enter proxy mode.
                dev_reg <= ddIn[7:0];
            end else if (!inDma && !proxy && wrFire && target == `DPD_A_DCTL) begin
                devCtl_reg <= ddIn[7:0];
            end else if (!inDma && !proxy && wrFire && target == `DPD_A_CMD) begin
                cmd_reg <= ddIn[7:0];
                cmdStrobe <= 1'b1;
            end
        end
    end
endmodule // dpd_port_decode

// ==== core/dpd_strobe_edge.v ====
`timescale 1ns/100ps
// Turns an active-low strobe level into a one-cycle pulse at its assertion.
module dpd_strobe_edge (
    input wire core_clk,
    input wire rst_n,
    input wire strobeN,
    output reg fire
);
    reg prevN_reg;

    // The previous level is held so that one strobe yields exactly one action.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevN_reg <= 1'b1;
            fire <= 1'b0;
        end else begin
            prevN_reg <= strobeN;
            fire <= prevN_reg & ~strobeN;
        end
    end
endmodule // dpd_strobe_edge

// ==== core/dpd_word_buf.v ====
`timescale 1ns/100ps
// Two-entry buffer with valid and ready on both sides.
module dpd_word_buf #(
    parameter WIDTH = 16
) (
    input wire core_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady
);
    reg [WIDTH-1:0] mem0_reg;
    reg [WIDTH-1:0] mem1_reg;
    reg [1:0] count_reg;
    wire push;
    wire pop;

    // Full and empty follow the count, so a stalled reader fills both slots.
    assign inReady = (count_reg != 2'd2);
    assign outValid = (count_reg != 2'd0);
    assign outData = mem0_reg;
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // Slot 0 is always the head; slot 1 shifts down on a pop.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem0_reg <= {WIDTH{1'b0}};
            mem1_reg <= {WIDTH{1'b0}};
            count_reg <= 2'd0;
        end else begin
            if (pop) begin
                mem0_reg <= (push && count_reg == 2'd1) ? inData : mem1_reg;
            end else if (push && count_reg == 2'd0) begin
                mem0_reg <= inData;
            end
            if (push && ((count_reg == 2'd1 && !pop) || count_reg == 2'd2)) begin
                mem1_reg <= inData;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // dpd_word_buf

// ==== sim/dpd_host_model.sv ====
`timescale 1ns/100ps
// Host adapter: moves its lines on falling edges and holds each strobe long
// enough for the registered answer, then idles before the next cycle.
module dpd_host_model (
    input wire core_clk,
    output logic cs0N,
    output logic cs1N,
    output logic [2:0] devAddr,
    output logic diorN,
    output logic diowN,
    output logic [15:0] ddIn,
    input wire [15:0] ddOut,
    input wire ddOeN
);
    // Idle bus: nothing selected, strobes high.
    initial begin
        {cs0N, cs1N, diorN, diowN} = 4'hf;
        devAddr = 3'h0;
        ddIn = 16'h0000;
    end

    // One cycle; a is {CS0 on, CS1 on, DA2..DA0}, q is {ddOeN, ddOut}.
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [15:0] d,
                        output logic [16:0] q);
        @(negedge core_clk);
        {cs0N, cs1N, devAddr} = {~a[4:3], a[2:0]};
        ddIn = rd ? ~ddIn : d;
        @(negedge core_clk);
        if (rd) diorN = 1'b0;
        else diowN = 1'b0;
        repeat (4) @(negedge core_clk);
        q = {ddOeN, ddOut};
        {diorN, diowN} = 2'h3;
        repeat (3) @(negedge core_clk);
        {cs0N, cs1N} = 2'h3;
        ddIn = ~ddIn; // A released bus must not keep showing old data.
    endtask
endmodule // dpd_host_model

// ==== sim/dpd_port_decode_sva.sv ====
`timescale 1ns/100ps
// Strobe answers appear two edges after the strobe is first sampled low.
// Outputs copied from internal registers appear one edge later still.
module dpd_port_decode_sva (
    input wire core_clk,
    input wire rst_n,
    input wire cs0N,
    input wire cs1N,
    input wire [2:0] devAddr,
    input wire diorN,
    input wire diowN,
    input wire dmackN,
    input wire [15:0] ddIn,
    input wire [15:0] ddOut,
    input wire ddOeN,
    input wire devNumber,
    input wire dev1Absent,
    input wire hasPacket,
    input wire busy,
    input wire drqIn,
    input wire dmaReq,
    input wire [7:0] errorIn,
    input wire dmaRdValid,
    input wire dmaRdTake,
    input wire selected,
    input wire nIenOut,
    input wire srstOut,
    input wire [7:0] featOut,
    input wire cmdStrobe,
    input wire diagStrobe,
    input wire burstEnd,
    input wire hostError
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Proxy answers only while device 1 is absent and this unit is idle.
    wire [4:0] adr = {~cs0N, ~cs1N, devAddr};
    wire pxy = dmackN && dev1Absent && !devNumber && !selected && !busy && !drqIn;
    wire dOk = !dmackN && cs0N && cs1N;
    wire ign = adr[4] == adr[3] || adr == 5'h10 || (adr[3] && devAddr != 3'h6);
    sequence sWr(c); $fell(diowN) && c; endsequence
    sequence sRd(c); $fell(diorN) && c; endsequence
    sequence sAny(c); ($fell(diowN) || $fell(diorN)) && c; endsequence

    AST_DCTL: assert property (sWr(pxy && adr == 5'h0E) |-> ##3 {srstOut, nIenOut} == ddIn[2:1])
        else $error("device control bits not stored");
    AST_ZERO: assert property (sRd(pxy && (adr == 5'h17 || adr == 5'h0E)) |-> ##2 !ddOeN && ddOut == 16'h0000)
        else $error("status read not zero");
    AST_FEAT: assert property (sWr(pxy && adr == 5'h11) |-> ##3 {8'h00, featOut} == ($past(ddIn, 3) & 16'h00ff))
        else $error("features byte not latched");
    AST_ERR: assert property (sRd(pxy && adr == 5'h11) |-> ##2 ddOut == {8'h00, $past(errorIn, 1)})
        else $error("error byte not returned");
    AST_PKT: assert property (sRd(pxy && hasPacket && adr >= 5'h12 && adr <= 5'h16) |-> ##2 ddOut == 16'h0000)
        else $error("packet unit shows shadow bytes");
    AST_SEL: assert property (sWr(dmackN && adr == 5'h16 && !busy && !drqIn && (selected || pxy)) |-> ##3 selected == (ddIn[4] == devNumber))
        else $error("selection not following unit bit");
    AST_DIAG: assert property (sWr(pxy && adr == 5'h17) |-> ##2 diagStrobe == (ddIn[7:0] == 8'h90) && !cmdStrobe ##1 !diagStrobe)
        else $error("proxy command handled wrongly");
    AST_IGN: assert property (sAny(pxy && ign) |-> ##2 ddOeN [*3] ##0 $stable(featOut))
        else $error("ignored strobe acted on");
    AST_CSE: assert property (sAny(!dmackN && !(cs0N && cs1N)) |-> ##2 hostError && !dmaRdTake)
        else $error("select during dma not refused");
    AST_BEND: assert property (sAny(dOk && !dmaReq) |-> ##2 burstEnd && !hostError)
        else $error("burst end not flagged");
    AST_WORD: assert property (sRd(dOk && dmaReq && (busy || drqIn) && dmaRdValid) |-> ##2 dmaRdTake ##1 !dmaRdTake)
        else $error("dma word not taken once");
endmodule // dpd_port_decode_sva

bind dpd_port_decode dpd_port_decode_sva u_sva (.*);

// ==== sim/tb_disk_port_dma_and_shadow_decode.sv ====
`timescale 1ns/100ps
// Host cycles against the decoder, with a word sink and source on the DMA side.
module tb_disk_port_dma_and_shadow_decode;
    logic core_clk, rst_n, dmackN, devNumber, dev1Absent, hasLba48, hasPacket;
    logic busy, drqIn, dmaReq, dmaRdValid, dmaWrReady, cs0N, cs1N, diorN, diowN;
    logic ddOeN, dmaRdTake, dmaWrValid, selected, nIenOut, srstOut;
    logic cmdStrobe, diagStrobe, burstEnd, hostError;
    logic [2:0] devAddr;
    logic [15:0] ddIn, ddOut, dmaRdData, dmaWrData, w [0:1];
    logic [15:0] got [$];
    logic [7:0] errorIn, featOut, cmdOut, v [0:7];
    logic [16:0] q;
    logic [31:0] r;
    logic [4:0] ig [0:4] = '{5'h00, 5'h18, 5'h10, 5'h0F, 5'h08};
    int n_errors, checks_done, cyc, nDiag, nCmd, nErr, nEnd, nTake, i, k;

    dpd_port_decode dut (.*);
    dpd_host_model h (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Packet units hide the shadowed bytes behind zero.
    function automatic logic [16:0] shadow(input logic [7:0] d, input logic pk);
        return pk ? 17'h0_0000 : {9'h000, d};
    endfunction

    task automatic chk(input string n, input logic [16:0] e, input logic [16:0] s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Pulse counters, the DMA word sink, and the hang limit.
    always @(posedge core_clk) begin
        if (diagStrobe === 1'b1) nDiag++;
        if (cmdStrobe === 1'b1) nCmd++;
        if (hostError === 1'b1) nErr++;
        if (burstEnd === 1'b1) nEnd++;
        if (dmaRdTake === 1'b1) nTake++;
        if (dmaWrValid === 1'b1 && dmaWrReady) got.push_back(dmaWrData);
        if (++cyc == 3000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        {rst_n, dmackN, devNumber, dev1Absent, hasLba48, hasPacket} = 6'h10;
        {busy, drqIn, dmaReq, dmaRdValid, dmaWrReady} = 5'h02;
        {dmaRdData, errorIn} = 24'h00_0000;
        r = 32'hb59d_8fcc;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        chk("ddOeN", 17'h1_0000, {ddOeN, 16'h0000});
        h.xfer(1'b0, 5'h16, 16'h0010, q);
        chk("selected", 17'h0_0000, {16'h0000, selected});
        {dev1Absent, hasLba48} = 2'h3;
        // Count written first and again later, so a previous byte exists.
        for (i = 0; i < 7; i++) begin
            r = lfsr(r);
            v[i] = r[7:0] | ((i == 6) ? 8'h10 : 8'h00);
            h.xfer(1'b0, (i == 0) ? 5'h12 : 5'(5'h10 + i), {8'h00, v[i]}, q);
        end
        for (k = 0; k < 2; k++) begin
            hasPacket = k[0];
            for (i = 2; i < 7; i++) begin
                h.xfer(1'b1, 5'(5'h10 + i), 16'h0000, q);
                chk("shadow", shadow(v[i], k[0]), q);
            end
        end
        hasPacket = 1'b0;
        h.xfer(1'b0, 5'h0E, 16'h0080, q);
        h.xfer(1'b1, 5'h12, 16'h0000, q);
        chk("hob", {9'h000, v[0]}, q);
        // Without the wide address feature the HOB bit has no effect.
        hasLba48 = 1'b0;
        h.xfer(1'b1, 5'h12, 16'h0000, q);
        chk("nohob", {9'h000, v[2]}, q);
        for (i = 0; i < 4; i++) begin
            h.xfer(1'b0, 5'h0E, 16'(6 - 2 * i), q);
            chk("dctl", 17'(3 - i), {15'h0000, srstOut, nIenOut});
        end
        errorIn = r[15:8];
        h.xfer(1'b1, 5'h11, 16'h0000, q);
        chk("error", {9'h000, errorIn}, q);
        chk("feat", {9'h000, v[1]}, {9'h000, featOut});
        h.xfer(1'b1, 5'h17, 16'h0000, q);
        chk("status", 17'h0_0000, q);
        h.xfer(1'b1, 5'h0E, 16'h0000, q);
        chk("altstatus", 17'h0_0000, q);
        for (i = 0; i < 10; i++) begin
            h.xfer(i[0], ig[i / 2], 16'h00a5, q);
            chk("ignored", {i[0], 8'h00, v[1]}, {q[16] & i[0], 8'h00, featOut});
        end
        v[7] = (r[23:16] == 8'h90) ? 8'h91 : r[23:16];
        h.xfer(1'b0, 5'h17, 16'h0090, q);
        h.xfer(1'b0, 5'h17, {8'h00, v[7]}, q);
        chk("cmd", {9'h000, v[7]}, {9'h000, cmdOut});
        chk("diag", 17'h0_0001, 17'(nDiag + 2 * nCmd));
        h.xfer(1'b0, 5'h16, 16'h0000, q);
        chk("selected", 17'h0_0001, {16'h0000, selected});
        // Two words pushed while the sink stalls, then drained.
        {dmackN, dmaReq, busy} = 3'h3;
        for (i = 0; i < 2; i++) begin
            r = lfsr(r);
            w[i] = r[15:0];
            h.xfer(1'b0, 5'h00, w[i], q);
            {busy, drqIn} = 2'h1;
        end
        dmaWrReady = 1'b1;
        for (k = 0; k < 20 && got.size() < 2; k++) @(negedge core_clk);
        chk("words", 17'h0_0002, 17'(got.size()));
        for (i = 0; i < got.size(); i++) chk("word", {1'b0, w[i]}, {1'b0, got[i]});
        dmaRdData = ~w[0];
        h.xfer(1'b1, 5'h00, 16'h0000, q);
        chk("dmaread", {1'b0, dmaRdData}, q);
        // With no word on offer the port drives zero and consumes nothing.
        dmaRdValid = 1'b0;
        h.xfer(1'b1, 5'h00, 16'h0000, q);
        chk("dmaempty", 17'h0_0000, q);
        chk("take", 17'h0_0001, 17'(nTake));
        dmaReq = 1'b0;
        h.xfer(1'b0, 5'h00, 16'h1234, q);
        chk("burstend", 17'h0_0001, 17'(nEnd + 2 * nErr));
        dmaReq = 1'b1;
        h.xfer(1'b0, 5'h17, 16'h0090, q);
        chk("hosterr", 17'h0_0011, 17'(nErr + 16 * nDiag));
        // The selected own unit takes a command and signals it once.
        dmackN = 1'b1;
        h.xfer(1'b0, 5'h17, 16'h00ec, q);
        chk("owncmd", 17'h0_01ec, {nCmd[8:0], cmdOut});
        results();
    end
endmodule // tb_disk_port_dma_and_shadow_decode
